// ===== verilog/adc_spi_readout_control.sv
`timescale 1ns/100ps
// What this block does
// - Conversion starts from SCLK, no frame sync
// - Sample from first rise to sixth zero
// - Result bits out on rising SCLK edges
// - Decide on rise, output one bit later
// - Early chip select rise truncates result
// - Doze at 16th fall, wake at 17th rise
// - Two frame sync latches; both high selects SPI
// - Chip select fall restarts the sequence
// - Chip select high: tristate, powered down
// - Six zero bits then ten result bits
module adc_spi_readout_control (
    input  wire logic                                   clk_sys_in,
    input  wire logic                                   reset_n_in,
    input  wire logic                                   chip_select_n_in,
    input  wire logic                                   sclk_in,
    input  wire logic                                   frame_sync_select_in,
    input  wire logic [adc_readout_pkg::RESULT_BITS-1:0] analog_input_in,
    output logic                                        serial_data_out,
    output logic                                        serial_data_oe_n_out,
    output logic                                        power_down_out,
    output logic                                        mode_spi_out,
    output logic                                        sampling_out
);

    adc_readout_pkg::pins_type                    pins_s;
    logic [adc_readout_pkg::RESULT_BITS-1:0]      analog_s;
    logic [adc_readout_pkg::SYNC_W-1:0]           sync_vec;
    logic                                         sclk_prev_q;
    logic                                         cs_prev_q;
    logic                                         sclk_rise;
    logic                                         sclk_fall;
    logic                                         cs_fall;
    logic                                         cs_high;
    adc_readout_pkg::state_type                   state_q;
    logic [1:0]                                   delay_q;
    logic                                         latch_a_q;
    logic                                         latch_b_q;
    logic [adc_readout_pkg::COUNT_W-1:0]          edge_cnt_q;
    logic [adc_readout_pkg::RESULT_BITS-1:0]      hold_q;
    logic [adc_readout_pkg::RESULT_BITS-1:0]      result_q;
    logic                                         decision_q;
    logic                                         conv_rise;
    logic                                         doze_rise;
    logic [adc_readout_pkg::COUNT_W-1:0]          dec_index;
    logic [adc_readout_pkg::RESULT_BITS-1:0]      trial;
    logic [adc_readout_pkg::RESULT_BITS-1:0]      dec_source;
    logic                                         dec_bit;

    // Analog word is a behavioural stand-in for the comparator path;
    // the host keeps it steady across the sample end, so bit skew is harmless
    pin_sync #(
        .WIDTH       (adc_readout_pkg::SYNC_W),
        .RESET_VALUE (adc_readout_pkg::SYNC_RESET)
    ) u_sync (
        .clk_sys_in (clk_sys_in),
        .reset_n_in (reset_n_in),
        .async_in   ({chip_select_n_in, sclk_in, frame_sync_select_in, analog_input_in}),
        .sync_out   (sync_vec)
    );

    assign pins_s   = sync_vec[adc_readout_pkg::SYNC_W-1:adc_readout_pkg::RESULT_BITS];
    assign analog_s = sync_vec[adc_readout_pkg::RESULT_BITS-1:0];

    always_ff @(posedge clk_sys_in) begin
        if (!reset_n_in) begin
            sclk_prev_q <= 1'b0;
            cs_prev_q   <= 1'b1;
        end else begin
            sclk_prev_q <= pins_s.sclk;
            cs_prev_q   <= pins_s.chip_select_n;
        end
    end

    assign sclk_rise = pins_s.sclk & ~sclk_prev_q;
    assign sclk_fall = ~pins_s.sclk & sclk_prev_q;
    assign cs_fall   = ~pins_s.chip_select_n & cs_prev_q;
    assign cs_high   = pins_s.chip_select_n;
    assign conv_rise = (state_q == adc_readout_pkg::ST_CONV) && sclk_rise &&
                       (edge_cnt_q < adc_readout_pkg::CNT_FRAME);
    assign doze_rise = (state_q == adc_readout_pkg::ST_DOZE) && sclk_rise;

    // Mode selection and power sequencing
    always_ff @(posedge clk_sys_in) begin
        if (!reset_n_in) begin
            state_q   <= adc_readout_pkg::ST_OFF;
            delay_q   <= adc_readout_pkg::DELAY_ZERO;
            latch_a_q <= 1'b0;
            latch_b_q <= 1'b0;
        end else if (cs_high) begin
            state_q <= adc_readout_pkg::ST_OFF;
        end else if (cs_fall) begin
            state_q   <= adc_readout_pkg::ST_MODE;
            latch_a_q <= pins_s.frame_sync_select;
            latch_b_q <= 1'b0;
            delay_q   <= adc_readout_pkg::MODE_DELAY_CYCLES;
        end else begin
            unique case (state_q)
                adc_readout_pkg::ST_OFF: begin
                    state_q <= adc_readout_pkg::ST_OFF;
                end
                adc_readout_pkg::ST_MODE: begin
                    if (delay_q == adc_readout_pkg::DELAY_ONE) begin
                        latch_b_q <= pins_s.frame_sync_select;
                        // Glitch on either latch falls back to DSP mode
                        if (latch_a_q && pins_s.frame_sync_select) begin
                            state_q <= adc_readout_pkg::ST_CONV;
                        end else begin
                            state_q <= adc_readout_pkg::ST_DSP;
                        end
                    end
                    delay_q <= delay_q - adc_readout_pkg::DELAY_ONE;
                end
                adc_readout_pkg::ST_CONV: begin
                    if (sclk_fall && edge_cnt_q == adc_readout_pkg::CNT_FRAME) begin
                        state_q <= adc_readout_pkg::ST_DOZE;
                    end
                end
                adc_readout_pkg::ST_DOZE: begin
                    if (sclk_rise) begin
                        state_q <= adc_readout_pkg::ST_CONV;
                    end
                end
                adc_readout_pkg::ST_DSP: begin
                    // Frame-sync driven mode is not carried further here
                    state_q <= adc_readout_pkg::ST_DSP;
                end
            endcase
        end
    end

    // Successive approximation decision for the current bit
    always_comb begin
        dec_index  = adc_readout_pkg::CNT_LAST_DEC - edge_cnt_q;
        trial      = result_q;
        trial[dec_index[3:0]] = 1'b1;
        dec_source = (edge_cnt_q == adc_readout_pkg::CNT_SAMPLE_END) ? analog_s : hold_q;
        dec_bit    = (dec_source >= trial);
    end

    // Edge counting, sampling and the conversion itself
    always_ff @(posedge clk_sys_in) begin
        if (!reset_n_in) begin
            edge_cnt_q   <= adc_readout_pkg::CNT_ZERO;
            sampling_out <= 1'b0;
            hold_q       <= '0;
            result_q     <= '0;
            decision_q   <= 1'b0;
        end else if (cs_high || cs_fall) begin
            edge_cnt_q   <= adc_readout_pkg::CNT_ZERO;
            sampling_out <= 1'b0;
            result_q     <= '0;
            decision_q   <= 1'b0;
        end else if (doze_rise) begin
            edge_cnt_q   <= adc_readout_pkg::CNT_ONE;
            sampling_out <= 1'b1;
            result_q     <= '0;
            decision_q   <= 1'b0;
        end else if (conv_rise) begin
            edge_cnt_q <= edge_cnt_q + adc_readout_pkg::CNT_ONE;
            if (edge_cnt_q == adc_readout_pkg::CNT_ZERO) begin
                sampling_out <= 1'b1;
            end
            if (edge_cnt_q == adc_readout_pkg::CNT_SAMPLE_END) begin
                sampling_out <= 1'b0;
                hold_q       <= analog_s;
            end
            // Decisions start on the edge that ends sampling, MSB first
            if (edge_cnt_q >= adc_readout_pkg::CNT_SAMPLE_END &&
                edge_cnt_q <= adc_readout_pkg::CNT_LAST_DEC) begin
                result_q[dec_index[3:0]] <= dec_bit;
                decision_q               <= dec_bit;
            end
        end
    end

    // Serial output: zeros, then each decision one edge after it was made
    always_ff @(posedge clk_sys_in) begin
        if (!reset_n_in) begin
            serial_data_out <= 1'b0;
        end else if (cs_high || cs_fall || doze_rise) begin
            serial_data_out <= 1'b0;
        end else if (conv_rise) begin
            if (edge_cnt_q < adc_readout_pkg::CNT_FIRST_OUT) begin
                serial_data_out <= 1'b0;
            end else begin
                serial_data_out <= decision_q;
            end
        end
    end

    // Driver enable and power indication
    always_ff @(posedge clk_sys_in) begin
        if (!reset_n_in) begin
            serial_data_oe_n_out <= 1'b1;
            power_down_out       <= 1'b1;
            mode_spi_out         <= 1'b0;
        end else begin
            serial_data_oe_n_out <= cs_high;
            power_down_out       <= cs_high ||
                                    (state_q == adc_readout_pkg::ST_OFF) ||
                                    (state_q == adc_readout_pkg::ST_DSP) ||
                                    ((state_q == adc_readout_pkg::ST_DOZE) && !sclk_rise) ||
                                    ((state_q == adc_readout_pkg::ST_CONV) && sclk_fall &&
                                     edge_cnt_q == adc_readout_pkg::CNT_FRAME);
            if (cs_high) begin
                mode_spi_out <= 1'b0;
            end else if (state_q == adc_readout_pkg::ST_MODE &&
                         delay_q == adc_readout_pkg::DELAY_ONE) begin
                mode_spi_out <= latch_a_q && pins_s.frame_sync_select;
            end
        end
    end

    default clocking cb @(posedge clk_sys_in); endclocking
    default disable iff (!reset_n_in);

    property p_cs_high_quiet;
        cs_high |=> serial_data_oe_n_out && power_down_out && !mode_spi_out;
    endproperty
    a_cs_high_quiet: assert property (p_cs_high_quiet)
        else $error("chip select high but output driven or powered");

    property p_cs_fall_restart;
        cs_fall |=> edge_cnt_q == adc_readout_pkg::CNT_ZERO &&
                    state_q == adc_readout_pkg::ST_MODE && !serial_data_oe_n_out;
    endproperty
    a_cs_fall_restart: assert property (p_cs_fall_restart)
        else $error("chip select fall did not restart the sequence");

    property p_mode_both_latches;
        $rose(state_q == adc_readout_pkg::ST_CONV) && $past(state_q == adc_readout_pkg::ST_MODE)
            |-> latch_a_q && latch_b_q;
    endproperty
    a_mode_both_latches: assert property (p_mode_both_latches)
        else $error("SPI mode entered without both latches high");

    property p_zero_bits;
        conv_rise && edge_cnt_q < adc_readout_pkg::CNT_FIRST_OUT |=> !serial_data_out;
    endproperty
    a_zero_bits: assert property (p_zero_bits)
        else $error("leading bit not zero");

    property p_bit_delayed;
        conv_rise && edge_cnt_q >= adc_readout_pkg::CNT_FIRST_OUT
            |=> serial_data_out == $past(decision_q);
    endproperty
    a_bit_delayed: assert property (p_bit_delayed)
        else $error("output bit is not the previous decision");

    property p_sample_window;
        conv_rise && edge_cnt_q == adc_readout_pkg::CNT_SAMPLE_END |=> !sampling_out ##0
            hold_q == $past(analog_s);
    endproperty
    a_sample_window: assert property (p_sample_window)
        else $error("sampling did not end on sixth zero edge");

    property p_sample_start;
        conv_rise && edge_cnt_q == adc_readout_pkg::CNT_ZERO |=> sampling_out;
    endproperty
    a_sample_start: assert property (p_sample_start)
        else $error("sampling did not start on first rise");

    property p_doze_at_16;
        state_q == adc_readout_pkg::ST_CONV && sclk_fall &&
        edge_cnt_q == adc_readout_pkg::CNT_FRAME && !cs_high
            |=> power_down_out ##1 state_q == adc_readout_pkg::ST_DOZE;
    endproperty
    a_doze_at_16: assert property (p_doze_at_16)
        else $error("no power down after sixteenth fall");

    property p_wake_17;
        doze_rise && !cs_high |=> !power_down_out && edge_cnt_q == adc_readout_pkg::CNT_ONE;
    endproperty
    a_wake_17: assert property (p_wake_17)
        else $error("no wake on seventeenth rise");

    property p_early_end;
        state_q == adc_readout_pkg::ST_CONV && cs_high |=> state_q == adc_readout_pkg::ST_OFF;
    endproperty
    a_early_end: assert property (p_early_end)
        else $error("early chip select rise not accepted");

    c_full_frame: cover property (state_q == adc_readout_pkg::ST_DOZE);
    c_spi_mode:   cover property ($rose(mode_spi_out));
    c_dsp_mode:   cover property (state_q == adc_readout_pkg::ST_DSP);
    c_truncated:  cover property (state_q == adc_readout_pkg::ST_CONV &&
                                  edge_cnt_q > adc_readout_pkg::CNT_FIRST_OUT && cs_high);

endmodule : adc_spi_readout_control

// ===== pkg/adc_readout_pkg.sv
package adc_readout_pkg;

    // Pins sampled from the host side, all asynchronous to clk_sys_in
    typedef struct packed {
        logic chip_select_n;
        logic sclk;
        logic frame_sync_select;
    } pins_type;

    localparam int unsigned RESULT_BITS  = 10;
    localparam int unsigned ZERO_BITS    = 6;
    localparam int unsigned FRAME_CLOCKS = 16;
    localparam int unsigned COUNT_W      = 5;
    localparam int unsigned PIN_COUNT    = 3;
    localparam int unsigned SYNC_W       = PIN_COUNT + RESULT_BITS;

    // Synchroniser reset matches idle pins, so no false chip select fall after reset
    localparam logic [SYNC_W-1:0] SYNC_RESET = {3'h5, {RESULT_BITS{1'b0}}};

    localparam logic [COUNT_W-1:0] CNT_ZERO       = 5'h00;
    localparam logic [COUNT_W-1:0] CNT_ONE        = 5'h01;
    // Rising edge count before the edge that sends the 6th zero bit
    localparam logic [COUNT_W-1:0] CNT_SAMPLE_END = 5'(ZERO_BITS - 1);
    localparam logic [COUNT_W-1:0] CNT_FIRST_OUT  = 5'(ZERO_BITS);
    localparam logic [COUNT_W-1:0] CNT_LAST_DEC   = 5'(FRAME_CLOCKS - 2);
    localparam logic [COUNT_W-1:0] CNT_FRAME      = 5'(FRAME_CLOCKS);

    // Internally delayed copy of the chip select fall for the second mode latch
    localparam int unsigned CLK_PERIOD_NS      = 25;
    localparam int unsigned MODE_DELAY_NS      = 50;
    localparam int unsigned MODE_DELAY_CYCLES_I =
        (MODE_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam logic [1:0]  MODE_DELAY_CYCLES  = 2'(MODE_DELAY_CYCLES_I);
    localparam logic [1:0]  DELAY_ZERO         = 2'h0;
    localparam logic [1:0]  DELAY_ONE          = 2'h1;

    typedef enum logic [4:0] {
        ST_OFF  = 5'h01,
        ST_MODE = 5'h02,
        ST_CONV = 5'h04,
        ST_DOZE = 5'h08,
        ST_DSP  = 5'h10
    } state_type;

endpackage : adc_readout_pkg

// ===== verilog/pin_sync.sv
`timescale 1ns/100ps
module pin_sync #(
    parameter int unsigned   WIDTH       = 1,
    parameter logic [WIDTH-1:0] RESET_VALUE = '0
) (
    input  wire logic             clk_sys_in,
    input  wire logic             reset_n_in,
    input  wire logic [WIDTH-1:0] async_in,
    output logic      [WIDTH-1:0] sync_out
);

    logic [WIDTH-1:0] meta_q;

    // First stage feeds only the second stage
    genvar i;
    generate
        for (i = 0; i < WIDTH; i++) begin : g_bit
            always_ff @(posedge clk_sys_in) begin
                if (!reset_n_in) begin
                    meta_q[i]   <= RESET_VALUE[i];
                    sync_out[i] <= RESET_VALUE[i];
                end else begin
                    meta_q[i]   <= async_in[i];
                    sync_out[i] <= meta_q[i];
                end
            end
        end
    endgenerate

endmodule : pin_sync

// ===== test/spi_host_model.sv
`timescale 1ns/100ps
module spi_host_model (
    input  wire logic clk_in,
    output logic      chip_select_n_out,
    output logic      sclk_out,
    output logic      frame_sync_select_out,
    input  wire logic serial_wire_in
);
    initial begin
        chip_select_n_out     = 1'b1;
        sclk_out              = 1'b0;
        frame_sync_select_out = 1'b1;
    end

    // Pins move by NBA on clk_in edges; one link clock is 8 clk_in cycles
    task automatic select(input logic fs_level, input logic fs_glitch);
        @(posedge clk_in);
        frame_sync_select_out <= fs_level;
        repeat (4) @(posedge clk_in);
        chip_select_n_out <= 1'b0;
        if (fs_glitch) begin
            @(posedge clk_in);
            frame_sync_select_out <= 1'b0;
        end
        repeat (19) @(posedge clk_in);
    endtask : select

    // Rise launches a bit, fall captures it
    task automatic run_clocks(input int n, input int pause_at, input int pause_cycles,
                              output logic [31:0] word);
        word = 32'h0000_0000;
        for (int i = 1; i <= n; i++) begin
            sclk_out <= 1'b1;
            repeat (4) @(posedge clk_in);
            word = {word[30:0], serial_wire_in};
            sclk_out <= 1'b0;
            repeat (4) @(posedge clk_in);
            if (i == pause_at) repeat (pause_cycles) @(posedge clk_in);
        end
    endtask : run_clocks

    task automatic deselect();
        repeat (4) @(posedge clk_in);
        chip_select_n_out     <= 1'b1;
        frame_sync_select_out <= 1'b1;
        repeat (16) @(posedge clk_in);
    endtask : deselect
endmodule : spi_host_model

// ===== test/adc_spi_readout_control_tb.sv
`timescale 1ns/100ps
module adc_spi_readout_control_tb;
    logic                                    clk_sys, reset_n, cs_n, sclk, fs;
    logic                                    data, oe_n, pd, mode_spi, sampling;
    logic                                    last_bit = 1'b0;
    logic                                    wire_level;
    logic [adc_readout_pkg::RESULT_BITS-1:0] analog;
    logic [31:0]                             word;
    int                                      n_mismatch, checked;

    initial begin
        clk_sys = 1'b0;
        forever #12.5 clk_sys = ~clk_sys;
    end

    // Released line shows the inverse of its last level, never a held value
    always @(posedge clk_sys) if (!oe_n) last_bit <= data;
    assign wire_level = oe_n ? ~last_bit : data;

    adc_spi_readout_control dut (
        .clk_sys_in          (clk_sys),
        .reset_n_in          (reset_n),
        .chip_select_n_in    (cs_n),
        .sclk_in             (sclk),
        .frame_sync_select_in(fs),
        .analog_input_in     (analog),
        .serial_data_out     (data),
        .serial_data_oe_n_out(oe_n),
        .power_down_out      (pd),
        .mode_spi_out        (mode_spi),
        .sampling_out        (sampling)
    );

    spi_host_model host (
        .clk_in               (clk_sys),
        .chip_select_n_out    (cs_n),
        .sclk_out             (sclk),
        .frame_sync_select_out(fs),
        .serial_wire_in       (wire_level)
    );

    task automatic print_verdict();
        $display("checked %0d mismatches %0d", checked, n_mismatch);
        if (n_mismatch == 0 && checked > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask : print_verdict

    task automatic check_bits(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            n_mismatch++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : check_bits

    task automatic check_flag(input logic got, input logic exp);
        check_bits({31'h0000_0000, got}, {31'h0000_0000, exp});
    endtask : check_flag

    task automatic set_input(input logic [9:0] value);
        @(posedge clk_sys);
        analog <= value;
    endtask : set_input

    task automatic open_frame(input logic fs_level, input logic fs_glitch);
        @(posedge clk_sys);
        host.select(fs_level, fs_glitch);
    endtask : open_frame

    task automatic test_back_to_back();
        logic [15:0] exp;
        exp = {6'h00, 10'h2A5};
        set_input(10'h2A5);
        open_frame(1'b1, 1'b0);
        check_flag(mode_spi, 1'b1);
        check_flag(oe_n, 1'b0);
        check_flag(pd, 1'b0);
        fork
            host.run_clocks(32, 16, 40, word);
            begin
                repeat (6) @(posedge clk_sys);
                check_flag(sampling, 1'b1);
                repeat (48) @(posedge clk_sys);
                check_flag(sampling, 1'b0);
                repeat (86) @(posedge clk_sys);
                check_flag(pd, 1'b1);
                repeat (34) @(posedge clk_sys);
                check_flag(pd, 1'b0);
                check_flag(sampling, 1'b1);
            end
        join
        check_bits(word, {exp, exp});
        host.deselect();
        check_flag(oe_n, 1'b1);
        check_flag(pd, 1'b1);
        check_flag(mode_spi, 1'b0);
        $display("test back_to_back done");
    endtask : test_back_to_back

    task automatic test_split_bursts();
        set_input(10'h1C3);
        open_frame(1'b1, 1'b0);
        // Pause of 50 us between the two bursts of eight
        host.run_clocks(16, 8, 2000, word);
        check_bits(word, {16'h0000, 6'h00, 10'h1C3});
        host.deselect();
        $display("test split_bursts done");
    endtask : test_split_bursts

    task automatic test_truncate();
        set_input(10'h35A);
        open_frame(1'b1, 1'b0);
        host.run_clocks(14, 0, 0, word);
        host.deselect();
        check_bits(word, 32'({6'h00, 10'h35A}) >> 2);
        check_flag(oe_n, 1'b1);
        set_input(10'h0C6);
        open_frame(1'b1, 1'b0);
        host.run_clocks(16, 0, 0, word);
        check_bits(word, {16'h0000, 6'h00, 10'h0C6});
        host.deselect();
        $display("test truncate done");
    endtask : test_truncate

    task automatic test_dsp_fallback();
        open_frame(1'b0, 1'b0);
        check_flag(mode_spi, 1'b0);
        check_flag(pd, 1'b1);
        host.run_clocks(16, 0, 0, word);
        check_bits(word, 32'h0000_0000);
        check_flag(sampling, 1'b0);
        host.deselect();
        // Second latch catches the low level after the fall
        open_frame(1'b1, 1'b1);
        check_flag(mode_spi, 1'b0);
        check_flag(pd, 1'b1);
        host.deselect();
        $display("test dsp_fallback done");
    endtask : test_dsp_fallback

    initial begin
        reset_n    = 1'b0;
        analog     = 10'h000;
        n_mismatch = 0;
        checked    = 0;
        repeat (8) @(posedge clk_sys);
        reset_n <= 1'b1;
        repeat (4) @(posedge clk_sys);
        check_flag(pd, 1'b1);
        check_flag(oe_n, 1'b1);
        test_back_to_back();
        test_split_bursts();
        test_truncate();
        test_dsp_fallback();
        print_verdict();
    end

    initial begin
        repeat (100000) @(posedge clk_sys);
        n_mismatch++;
        $display("run limit reached");
        print_verdict();
    end
endmodule : adc_spi_readout_control_tb
